// *** logic/adc_flags_defs.svh ***
// Purpose: Offsets, field positions, reset values and framing counts for the result and flag bank
// Assumes: Included by bare name; definitions only
// Notes: Offsets are register indexes on the serial port, not byte addresses
`ifndef ADC_FLAGS_DEFS_SVH
`define ADC_FLAGS_DEFS_SVH

`define ADDR_W 7
`define WORD_W 24
`define RESULT_BASE_OFS 7'h30
`define RESULT_SIX_OFS 7'h36
`define RESULT_SEVEN_OFS 7'h37
`define EVENT_FLAGS_OFS 7'h38
`define EVENT_MASK_OFS 7'h39
`define SLOT_SIX 3'h6
`define SLOT_SEVEN 3'h7
`define ABOVE_MSB 23
`define ABOVE_LSB 16
`define BELOW_MSB 15
`define BELOW_LSB 8
`define GAIN_OVF_BIT 7
`define UNREAD_BIT 4
`define WAIT_BIT 3
`define CAL_BIT 2
`define SEQ_BIT 1
`define CONV_BIT 0
`define EVENT_MASK_RST 24'h000001
`define CMD_BITS 6'h08
`define FRAME_BITS 6'h20

`endif

// *** logic/adc_flags_pkg.sv ***
// Purpose: Types shared by the result and flag bank
// Assumes: Used by scoped name only
// Notes: Frame phases are Gray coded along the normal path
package adc_flags_pkg;

  // Serial frame phase: command byte, data word, then wait for deselect
  typedef enum logic [1:0] {
    PH_CMD = 2'b00,
    PH_DATA = 2'b01,
    PH_DONE = 2'b11
  } frame_phase_e;

  typedef logic [23:0] word_t;

endpackage : adc_flags_pkg

// *** logic/pin_sync.sv ***
// Purpose: Two-flop synchroniser for the serial port pins
// Assumes: Pins are asynchronous to clk_i
// Notes: Stage one is read only by stage two
`timescale 1ns/1ps
module pin_sync #(
  parameter logic [2:0] RST_VAL = 3'h0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Pins in, synchronised out
  input wire logic [2:0] pin_i,
  output logic [2:0] sync_o
);

  logic [2:0] meta_reg;

  // Two stages to settle metastability
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      meta_reg <= RST_VAL;
      sync_o <= RST_VAL;
    end else begin
      meta_reg <= pin_i;
      sync_o <= meta_reg;
    end
  end

endmodule : pin_sync

// *** logic/result_store.sv ***
// Purpose: Holds result slots six and seven
// Assumes: One write and one read per cycle
// Notes: Read data comes from a register, one cycle after the address
`timescale 1ns/1ps
module result_store (
  // Clock
  input wire logic clk_i,
  // Write port
  input wire logic wr_en_i,
  input wire logic wr_sel_i,
  input wire logic [23:0] wr_data_i,
  // Read port
  input wire logic rd_sel_i,
  output logic [23:0] rd_data_o
);

  adc_flags_pkg::word_t mem [0:1];

  // Contents carry no reset; they are defined by the first write, from a conversion or the port
  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem[wr_sel_i] <= wr_data_i;
    end
  end

  // Registered read
  always_ff @(posedge clk_i) begin
    rd_data_o <= mem[rd_sel_i];
  end

endmodule : result_store

// *** logic/adc_result_flags.sv ***
// Purpose: Result slots six and seven, event flag register and interrupt mask on a serial port
// Assumes: Serial clock at most one eighth of clk_i; converter events are one-cycle pulses
// Notes: Frame is 8 command bits (read bit, 7-bit index) then 24 data bits, MSB first, mode 0
`timescale 1ns/1ps
`include "adc_flags_defs.svh"
module adc_result_flags (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Serial port pins
  input wire logic spi_cs_n_i,
  input wire logic spi_sclk_i,
  input wire logic spi_mosi_i,
  output logic spi_miso_o,
  output logic spi_miso_oe_o,
  // Converter results
  input wire logic result_valid_i,
  input wire logic [2:0] result_target_select_i,
  input wire logic [23:0] result_data_i,
  // Per-channel range events
  input wire logic [7:0] above_limit_i,
  input wire logic [7:0] digital_over_i,
  input wire logic [7:0] below_limit_i,
  input wire logic [7:0] digital_under_i,
  // Calibration, wait, sequencer and conversion events
  input wire logic gain_cal_done_i,
  input wire logic gain_cal_over_i,
  input wire logic cal_stored_i,
  input wire logic wait_done_i,
  input wire logic seq_pass_i,
  input wire logic seq_wrap_i,
  input wire logic conv_pre_result_i,
  // Launch register writes seen by neighbouring logic
  input wire logic wait_launch_wr_i,
  input wire logic cal_launch_wr_i,
  input wire logic sequence_launch_wr_i,
  input wire logic conversion_launch_wr_i,
  // Interrupt
  output logic interrupt_out_n
);

  // Index of a result slot, valid when is_result_ofs holds
  function automatic logic [2:0] slot_of(input logic [6:0] ofs);
    slot_of = ofs[2:0];
  endfunction : slot_of

  function automatic logic is_result_ofs(input logic [6:0] ofs);
    is_result_ofs = ({ofs[6:3], 3'h0} == `RESULT_BASE_OFS);
  endfunction : is_result_ofs

  logic [2:0] pins_s;
  logic sclk_d_reg;
  logic cs_n_s;
  logic sclk_rise, sclk_fall, cmd_done, frame_done, status_rd, data_rd, eng_wr, spi_wr;
  logic [5:0] bit_cnt_reg;
  logic [31:0] rx_reg;
  logic rd_pend_reg;
  logic [6:0] ofs_reg;
  logic [23:0] tx_reg, flags_snap_reg, flags, mem_rdata, wdata, mask_reg;
  adc_flags_pkg::frame_phase_e phase_reg;
  logic [7:0] above_reg, below_reg, unread_reg;
  logic gain_ovf_reg, wait_reg, cal_reg, seq_reg, conv_reg;

  // Pins pass two flops before any logic sees them; idle chip select is high
  pin_sync #(
    .RST_VAL(3'h4)
  ) u_sync (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .pin_i({spi_cs_n_i, spi_sclk_i, spi_mosi_i}),
    .sync_o(pins_s)
  );

  assign cs_n_s = pins_s[2];

  // Edge detect on the settled serial clock
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sclk_d_reg <= 1'b0;
    end else begin
      sclk_d_reg <= pins_s[1];
    end
  end

  assign sclk_rise = pins_s[1] & ~sclk_d_reg & ~cs_n_s;
  assign sclk_fall = ~pins_s[1] & sclk_d_reg & ~cs_n_s;
  assign cmd_done = sclk_rise && (phase_reg == adc_flags_pkg::PH_CMD)
                    && (bit_cnt_reg == `CMD_BITS - 6'h01);
  assign frame_done = sclk_rise && (phase_reg == adc_flags_pkg::PH_DATA)
                      && (bit_cnt_reg == `FRAME_BITS - 6'h01);
  // The last index bit is still on the pin flop, not yet in rx_reg
  assign status_rd = cmd_done && rx_reg[6] && ({rx_reg[5:0], pins_s[0]} == `EVENT_FLAGS_OFS);

  // Frame phase and bit count; deselect aborts any partial frame
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || cs_n_s) begin
      phase_reg <= adc_flags_pkg::PH_CMD;
      bit_cnt_reg <= 6'h00;
    end else if (sclk_rise) begin
      bit_cnt_reg <= bit_cnt_reg + 6'h01;
      case (phase_reg)
        adc_flags_pkg::PH_CMD: begin
          if (cmd_done) begin
            phase_reg <= adc_flags_pkg::PH_DATA;
          end
        end
        adc_flags_pkg::PH_DATA: begin
          if (frame_done) begin
            phase_reg <= adc_flags_pkg::PH_DONE;
          end
        end
        default: begin
          phase_reg <= adc_flags_pkg::PH_DONE;
        end
      endcase
    end
  end

  // Shift register for incoming bits
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rx_reg <= 32'h0000_0000;
    end else if (sclk_rise) begin
      rx_reg <= {rx_reg[30:0], pins_s[0]};
    end
  end

  // Index is latched when the command byte completes
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ofs_reg <= 7'h00;
      rd_pend_reg <= 1'b0;
    end else begin
      rd_pend_reg <= cmd_done && rx_reg[6];
      if (cmd_done) begin
        ofs_reg <= {rx_reg[5:0], pins_s[0]};
      end
    end
  end

  assign data_rd = cmd_done && rx_reg[6] && is_result_ofs({rx_reg[5:0], pins_s[0]});

  // Engine writes take the store before the port; a colliding port write is dropped
  assign eng_wr = result_valid_i && (result_target_select_i == `SLOT_SIX
                  || result_target_select_i == `SLOT_SEVEN);
  assign spi_wr = frame_done && ~rx_reg[30]
                  && (rx_reg[29:23] == `RESULT_SIX_OFS || rx_reg[29:23] == `RESULT_SEVEN_OFS);
  assign wdata = eng_wr ? result_data_i : {rx_reg[22:0], pins_s[0]};

  result_store u_store (
    .clk_i(clk_i),
    .wr_en_i(eng_wr || spi_wr),
    .wr_sel_i(eng_wr ? result_target_select_i[0] : rx_reg[23]),
    .wr_data_i(wdata),
    .rd_sel_i(pins_s[0]),
    .rd_data_o(mem_rdata)
  );

  // Flag word; bits 6 and 5 are hard zero
  assign flags = {above_reg, below_reg, gain_ovf_reg, 2'b00, |unread_reg,
                  wait_reg, cal_reg, seq_reg, conv_reg};

  // Snapshot taken at the read so the word reflects its start
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      flags_snap_reg <= 24'h000000;
    end else if (cmd_done) begin
      flags_snap_reg <= flags;
    end
  end

  // Output shifter: load one cycle after the command, shift on falling edges
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      tx_reg <= 24'h000000;
      spi_miso_o <= 1'b0;
    end else if (rd_pend_reg) begin
      if (ofs_reg == `EVENT_FLAGS_OFS) begin
        tx_reg <= flags_snap_reg;
      end else if (ofs_reg == `EVENT_MASK_OFS) begin
        tx_reg <= mask_reg;
      end else if (ofs_reg == `RESULT_SIX_OFS || ofs_reg == `RESULT_SEVEN_OFS) begin
        tx_reg <= mem_rdata;
      end else begin
        tx_reg <= 24'h000000;
      end
    end else if (sclk_fall && phase_reg == adc_flags_pkg::PH_DATA) begin
      spi_miso_o <= tx_reg[23];
      tx_reg <= {tx_reg[22:0], 1'b0};
    end
  end

  // Drive the data line only while selected
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      spi_miso_oe_o <= 1'b0;
    end else begin
      spi_miso_oe_o <= ~cs_n_s;
    end
  end

  // Range flags: sticky, cleared only by a flag read, a new event wins the clear
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      above_reg <= 8'h00;
      below_reg <= 8'h00;
    end else begin
      above_reg <= (above_reg & {8{~status_rd}}) | above_limit_i | digital_over_i;
      below_reg <= (below_reg & {8{~status_rd}}) | below_limit_i | digital_under_i;
    end
  end

  // Gain calibration overflow: a valid later calibration also clears it
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      gain_ovf_reg <= 1'b0;
    end else if (gain_cal_done_i && gain_cal_over_i) begin
      gain_ovf_reg <= 1'b1;
    end else if (status_rd || gain_cal_done_i) begin
      gain_ovf_reg <= 1'b0;
    end
  end

  // Hidden unread bits, one per result slot, untouched by a flag read
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      unread_reg <= 8'h00;
    end else begin
      for (int k = 0; k < 8; k++) begin
        if (result_valid_i && result_target_select_i == 3'(k)) begin
          unread_reg[k] <= 1'b1;
        end else if (data_rd && slot_of({rx_reg[5:0], pins_s[0]}) == 3'(k)) begin
          unread_reg[k] <= 1'b0;
        end
      end
    end
  end

  // Ready flags: set wins over every clear source
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wait_reg <= 1'b0;
      cal_reg <= 1'b0;
      seq_reg <= 1'b0;
      conv_reg <= 1'b0;
    end else begin
      wait_reg <= wait_done_i | (wait_reg & ~(status_rd | wait_launch_wr_i));
      cal_reg <= cal_stored_i | (cal_reg & ~(status_rd | cal_launch_wr_i));
      seq_reg <= seq_pass_i
                 | (seq_reg & ~(status_rd | sequence_launch_wr_i | seq_wrap_i));
      conv_reg <= result_valid_i
                  | (conv_reg & ~(status_rd | conversion_launch_wr_i | conv_pre_result_i));
    end
  end

  // Interrupt mask, written whole at the end of a write frame
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      mask_reg <= `EVENT_MASK_RST;
    end else if (frame_done && ~rx_reg[30] && rx_reg[29:23] == `EVENT_MASK_OFS) begin
      mask_reg <= {rx_reg[22:0], pins_s[0]};
    end
  end

  // Registered active-low interrupt; one cycle behind the flags
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      interrupt_out_n <= 1'b1;
    end else begin
      interrupt_out_n <= ~|(flags & mask_reg);
    end
  end

  // Checks

  sequence s_flag_read;
    status_rd;
  endsequence

  property p_above_sticky;
    @(posedge clk_i) disable iff (sys_rst_i)
    (above_reg[0] && !status_rd) |=> above_reg[0];
  endproperty
  a_above_sticky: assert property (p_above_sticky) else $error("above flag lost");
  property p_below_set;
    @(posedge clk_i) disable iff (sys_rst_i)
    (below_limit_i[3] || digital_under_i[3]) |=> below_reg[3];
  endproperty
  a_below_set: assert property (p_below_set) else $error("below flag not set");
  property p_unread_survives_read;
    @(posedge clk_i) disable iff (sys_rst_i)
    s_flag_read ##0 ((|unread_reg) && !data_rd) |=> |unread_reg;
  endproperty
  a_unread_survives_read: assert property (p_unread_survives_read)
    else $error("unread cleared by flag read");
  property p_slot_seven_unread;
    @(posedge clk_i) disable iff (sys_rst_i)
    (result_valid_i && result_target_select_i == 3'h7) |=> unread_reg[7] ##0 flags[4];
  endproperty
  a_slot_seven_unread: assert property (p_slot_seven_unread)
    else $error("slot seven unread not raised");
  property p_wait_clear;
    @(posedge clk_i) disable iff (sys_rst_i)
    (wait_launch_wr_i && !wait_done_i) |=> !wait_reg;
  endproperty
  a_wait_clear: assert property (p_wait_clear) else $error("wait flag not cleared");
  property p_conv_set_wins;
    @(posedge clk_i) disable iff (sys_rst_i)
    (result_valid_i && (status_rd || conv_pre_result_i)) |=> conv_reg;
  endproperty
  a_conv_set_wins: assert property (p_conv_set_wins) else $error("new result flag lost");
  property p_seq_wrap;
    @(posedge clk_i) disable iff (sys_rst_i)
    (seq_wrap_i && !seq_pass_i) |=> !seq_reg;
  endproperty
  a_seq_wrap: assert property (p_seq_wrap) else $error("sequence flag kept on wrap");
  property p_irq_follows;
    @(posedge clk_i) disable iff (sys_rst_i)
    (|(flags & mask_reg)) |=> !interrupt_out_n;
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("interrupt not asserted");
  property p_reserved_zero;
    @(posedge clk_i) disable iff (sys_rst_i)
    rd_pend_reg && ofs_reg == `EVENT_FLAGS_OFS |=> tx_reg[6:5] == 2'b00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");
  property p_gain_valid_clear;
    @(posedge clk_i) disable iff (sys_rst_i)
    (gain_cal_done_i && !gain_cal_over_i) |=> !gain_ovf_reg;
  endproperty
  a_gain_valid_clear: assert property (p_gain_valid_clear)
    else $error("gain overflow kept");

endmodule : adc_result_flags

// *** tb/spi_host_model.sv ***
// Purpose: Host side of the serial port, runs one command frame per call
// Assumes: Mode 0; sclk half period of eight clk_i cycles, inside the clk/8 limit
// Notes: Data out toggles while deselected so no one leans on a stale bit
`timescale 1ns/1ps
module spi_host_model (
  // Clock
  input wire logic clk_i,
  // Serial pins
  output logic spi_cs_n_o,
  output logic spi_sclk_o,
  output logic spi_mosi_o,
  input wire logic spi_miso_i
);
  initial begin
    spi_cs_n_o = 1'b1;
    spi_sclk_o = 1'b0;
    spi_mosi_o = 1'b0;
  end

  // Idle line keeps changing between frames
  always @(posedge clk_i) begin
    if (spi_cs_n_o) begin
      spi_mosi_o <= ~spi_mosi_o;
    end
  end

  // Read bit, index, then a word; read data is taken at each rising sclk of the data word
  task automatic xfer(input logic rd, input logic [6:0] idx, input logic [23:0] wd,
                      output logic [23:0] rdat);
    logic [31:0] sh;
    sh = {rd, idx, wd};
    rdat = 24'h000000;
    @(posedge clk_i);
    spi_cs_n_o <= 1'b0;
    repeat (8) @(posedge clk_i);
    for (int i = 0; i < 32; i++) begin
      spi_mosi_o <= sh[31 - i];
      repeat (8) @(posedge clk_i);
      if (i >= 8) begin
        rdat = {rdat[22:0], spi_miso_i};
      end
      spi_sclk_o <= 1'b1;
      repeat (8) @(posedge clk_i);
      spi_sclk_o <= 1'b0;
    end
    repeat (8) @(posedge clk_i);
    spi_cs_n_o <= 1'b1;
    repeat (8) @(posedge clk_i); // Gap between frames well above four clocks
  endtask : xfer
endmodule : spi_host_model

// *** tb/testbench.sv ***
// Purpose: Self-checking bench for the result slots and event flags
// Assumes: Events are single-cycle pulses driven away from any frame
// Notes: Expected values come from a flag model kept in integers and vectors
`timescale 1ns/1ps
`include "adc_flags_defs.svh"
module testbench;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic cs_n, sclk, mosi, miso, irq_n, rv, gov, oe;
  logic [2:0] tsel;
  logic [23:0] rdata;
  logic [7:0] ab, ov, be, un;
  logic [9:0] ev;
  logic [23:0] fl_m, mask_m, d;
  logic [7:0] unread_m;
  logic [23:0] slot_m [8];
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;
  int seed;

  always #5 clk_i = ~clk_i;

  spi_host_model host (.clk_i(clk_i), .spi_cs_n_o(cs_n), .spi_sclk_o(sclk),
    .spi_mosi_o(mosi), .spi_miso_i(miso));

  adc_result_flags dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .spi_cs_n_i(cs_n),
    .spi_sclk_i(sclk), .spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_o(oe),
    .result_valid_i(rv), .result_target_select_i(tsel), .result_data_i(rdata),
    .above_limit_i(ab), .digital_over_i(ov), .below_limit_i(be), .digital_under_i(un),
    .gain_cal_done_i(ev[0]), .gain_cal_over_i(gov), .cal_stored_i(ev[1]),
    .wait_done_i(ev[2]), .seq_pass_i(ev[3]), .seq_wrap_i(ev[4]),
    .conv_pre_result_i(ev[5]), .wait_launch_wr_i(ev[6]), .cal_launch_wr_i(ev[7]),
    .sequence_launch_wr_i(ev[8]), .conversion_launch_wr_i(ev[9]),
    .interrupt_out_n(irq_n));

  // Hang guard, sized well above the roughly 18k cycles the tests need
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Data line must be driven whenever the host clocks a bit in
  always @(posedge sclk) begin
    check({23'h000000, oe}, 24'h000001);
  end

  // Flag register as the model sees it; unread bit is the OR of all slots
  function automatic logic [23:0] stat_m();
    return fl_m | {19'h00000, |unread_m, 4'h0};
  endfunction : stat_m

  task automatic chk_int();
    check({23'h000000, irq_n}, {23'h000000, ~|(stat_m() & mask_m)});
  endtask : chk_int

  // One-cycle event pulse; clears go first in the model so a set wins
  task automatic pulse(input logic [9:0] e, input logic [7:0] a, o, b, u, input logic g);
    @(posedge clk_i);
    ev <= e;
    ab <= a;
    ov <= o;
    be <= b;
    un <= u;
    gov <= g;
    @(posedge clk_i);
    ev <= 10'h000;
    ab <= 8'h00;
    ov <= 8'h00;
    be <= 8'h00;
    un <= 8'h00;
    fl_m[23:16] = fl_m[23:16] | a | o;
    fl_m[15:8] = fl_m[15:8] | b | u;
    if (e[0]) fl_m[7] = g;
    if (e[6]) fl_m[3] = 1'b0;
    if (e[7]) fl_m[2] = 1'b0;
    if (e[8] | e[4]) fl_m[1] = 1'b0;
    if (e[9] | e[5]) fl_m[0] = 1'b0;
    if (e[2]) fl_m[3] = 1'b1;
    if (e[1]) fl_m[2] = 1'b1;
    if (e[3]) fl_m[1] = 1'b1;
    repeat (3) @(posedge clk_i);
    chk_int();
  endtask : pulse

  task automatic result(input logic [2:0] s, input logic [23:0] v);
    @(posedge clk_i);
    rv <= 1'b1;
    tsel <= s;
    rdata <= v;
    @(posedge clk_i);
    rv <= 1'b0;
    slot_m[s] = v;
    unread_m[s] = 1'b1;
    fl_m[0] = 1'b1;
    repeat (3) @(posedge clk_i);
    chk_int();
  endtask : result

  task automatic rd_reg(input logic [6:0] idx);
    logic [23:0] got;
    logic [23:0] exp;
    host.xfer(1'b1, idx, 24'h000000, got);
    exp = 24'h000000;
    if (idx == `EVENT_FLAGS_OFS) begin
      exp = stat_m();
      fl_m = 24'h000000;
    end else if (idx == `EVENT_MASK_OFS) begin
      exp = mask_m;
    end else if (idx[6:3] == 4'h6) begin
      if (idx[2:1] == 2'b11) exp = slot_m[idx[2:0]];
      unread_m[idx[2:0]] = 1'b0;
    end
    check(got, exp);
    check({23'h000000, oe}, 24'h000000);
    chk_int();
  endtask : rd_reg

  task automatic wr_reg(input logic [6:0] idx, input logic [23:0] wd);
    logic [23:0] unused;
    host.xfer(1'b0, idx, wd, unused);
    if (idx == `EVENT_MASK_OFS) mask_m = wd;
    if (idx[6:1] == 6'h1b) slot_m[idx[2:0]] = wd;
  endtask : wr_reg

  // Set and clear events in pairs: wait, calibration, sequence twice
  logic [9:0] set_t [4] = '{10'h004, 10'h002, 10'h008, 10'h008};
  logic [9:0] clr_t [4] = '{10'h040, 10'h080, 10'h100, 10'h010};

  initial begin
    {rv, gov, ev, ab, ov, be, un} = '0;
    tsel = 3'h0;
    rdata = 24'h000000;
    fl_m = 24'h000000;
    unread_m = 8'h00;
    mask_m = `EVENT_MASK_RST;
    seed = $urandom(13);
    repeat (16) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk_int();
    rd_reg(`EVENT_MASK_OFS);
    rd_reg(`EVENT_FLAGS_OFS);
    $display("reset test done");
    result(`SLOT_SEVEN, $urandom);
    rd_reg(`EVENT_FLAGS_OFS);
    rd_reg(`EVENT_FLAGS_OFS);
    rd_reg(`RESULT_SEVEN_OFS);
    rd_reg(`EVENT_FLAGS_OFS);
    result(`SLOT_SIX, $urandom);
    result(`SLOT_SIX, $urandom);
    result(3'h3, $urandom);
    rd_reg(`RESULT_SIX_OFS);
    rd_reg(`EVENT_FLAGS_OFS);
    rd_reg(7'h33);
    rd_reg(`EVENT_FLAGS_OFS);
    result(`SLOT_SIX, $urandom);
    rd_reg(`EVENT_FLAGS_OFS);
    wr_reg(`RESULT_SIX_OFS, $urandom);
    rd_reg(`RESULT_SIX_OFS);
    wr_reg(`RESULT_SEVEN_OFS, $urandom);
    rd_reg(`RESULT_SEVEN_OFS);
    $display("result test done");
    for (int ch = 0; ch < 8; ch++) begin
      pulse(10'h000, 8'h01 << ch, 8'h00, 8'h00, 8'h80 >> ch, 1'b0);
      pulse(10'h000, 8'h00, $urandom, $urandom, 8'h00, 1'b0);
    end
    repeat (300) @(posedge clk_i);
    rd_reg(`EVENT_FLAGS_OFS);
    rd_reg(`EVENT_FLAGS_OFS);
    $display("range test done");
    pulse(10'h001, 8'h00, 8'h00, 8'h00, 8'h00, 1'b1);
    rd_reg(`EVENT_FLAGS_OFS);
    pulse(10'h001, 8'h00, 8'h00, 8'h00, 8'h00, 1'b1);
    pulse(10'h001, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0);
    rd_reg(`EVENT_FLAGS_OFS);
    $display("gain test done");
    wr_reg(`EVENT_MASK_OFS, 24'hfffd9f);
    for (int i = 0; i < 4; i++) begin
      pulse(set_t[i], 8'h00, 8'h00, 8'h00, 8'h00, 1'b0);
      pulse(clr_t[i], 8'h00, 8'h00, 8'h00, 8'h00, 1'b0);
    end
    result(3'h0, $urandom);
    pulse(10'h200, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0);
    result(3'h1, $urandom);
    pulse(10'h020, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0);
    pulse(10'h044, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0);
    rd_reg(7'h30);
    rd_reg(7'h31);
    rd_reg(`EVENT_FLAGS_OFS);
    $display("launch test done");
    for (int k = 0; k < 4; k++) begin
      wr_reg(`EVENT_MASK_OFS, $urandom & 24'hfffd9f);
      pulse($urandom & 10'h08f, $urandom, 8'h00, $urandom, 8'h00, 1'b1);
      rd_reg(`EVENT_FLAGS_OFS);
    end
    $display("mask test done");
    pulse(10'h00f, 8'h00, 8'h00, 8'h00, 8'h00, 1'b1);
    wr_reg(`EVENT_FLAGS_OFS, 24'hffffff);
    rd_reg(`EVENT_FLAGS_OFS);
    $display("write-ignore test done");
    give_verdict();
  end
endmodule : testbench
